//--- hdl/caes_consts.vh
// Constants for the address and exception sequencer.
// Assumes an 8-bit core with a 16-bit linear address space.
`ifndef CAES_CONSTS_VH
`define CAES_CONSTS_VH

// ----------------------------------------
// Address modes
// ----------------------------------------
`define CAES_AM_PAGE0      4'h0
`define CAES_AM_FULL       4'h1
`define CAES_AM_PAIR       4'h2
`define CAES_AM_PAIR_INC   4'h3
`define CAES_AM_PAIR_B     4'h4
`define CAES_AM_PAIR_B_INC 4'h5
`define CAES_AM_PAIR_W     4'h6
`define CAES_AM_STK_B      4'h7
`define CAES_AM_STK_W      4'h8

// ----------------------------------------
// Vectors, flag positions, timing
// ----------------------------------------
`define CAES_RESET_VEC_HI  16'hFFFE
`define CAES_RESET_VEC_LO  16'hFFFF
`define CAES_PAGE0_HIGH    8'h00
`define CAES_INC_ONE       16'h0001
`define CAES_MASK_BIT      3
`define CAES_RESET_CYCLES  3'h6
`define CAES_QUEUE_BYTES   2'h3
`define CAES_STACK_BYTES   3'h5

`endif

//--- hdl/caes_addr_gen.v
// Effective-address generator for operand accesses.
// Assumes the instruction bytes and base registers are stable while used.
`timescale 1ns/10ps
`include "caes_consts.vh"

module caes_addr_gen (
  input  wire [3:0]  addrMode,    // Selected address mode
  input  wire [15:0] operandWord, // Instruction operand bytes, first byte high
  input  wire [15:0] indexPair,   // Upper and low index bytes
  input  wire [15:0] stackPtr,    // Stack pointer
  output reg  [15:0] effAddr,     // Operand address
  output reg         postInc      // Index pair is bumped after the fetch
);

  always @* begin
    effAddr = indexPair;
    postInc = 1'b0;
    case (addrMode)
      `CAES_AM_PAGE0:      effAddr = {`CAES_PAGE0_HIGH, operandWord[7:0]};
      `CAES_AM_FULL:       effAddr = operandWord;
      `CAES_AM_PAIR:       effAddr = indexPair;
      `CAES_AM_PAIR_INC: begin
        effAddr = indexPair;
        postInc = 1'b1;
      end
      `CAES_AM_PAIR_B:     effAddr = indexPair + {8'h00, operandWord[7:0]};
      `CAES_AM_PAIR_B_INC: begin
        effAddr = indexPair + {8'h00, operandWord[7:0]};
        postInc = 1'b1;
      end
      `CAES_AM_PAIR_W:     effAddr = indexPair + operandWord;
      `CAES_AM_STK_B:      effAddr = stackPtr + {8'h00, operandWord[7:0]};
      `CAES_AM_STK_W:      effAddr = stackPtr + operandWord;
      default:             effAddr = indexPair;
    endcase
  end

endmodule

//--- hdl/caes_prio_enc.v
// Priority picker for pending interrupt requests.
// Assumes request bit 0 has the highest priority.
`timescale 1ns/10ps

module caes_prio_enc (
  input  wire [7:0] reqLines, // Pending requests
  output reg  [2:0] winIdx,   // Index of highest-priority request
  output reg        anyReq    // Some request pending
);

  integer i;

  always @* begin
    winIdx = 3'h0;
    anyReq = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (reqLines[i]) begin
        winIdx = i[2:0];
        anyReq = 1'b1;
      end
    end
  end

endmodule

//--- hdl/caes_sequencer.v
// Notes on behaviour
// - Page-zero address is zero high byte above the instruction byte.
// - Full address comes from two program bytes, high byte first.
// - Pair-base address is the index pair itself, no offset.
// - Post-increment modes add one to the index pair after operand fetch.
// - Pair-byte-offset adds a zero-extended byte to the index pair.
// - Pair-word-offset adds a 16-bit offset to the index pair.
// - Stack-byte-offset adds a zero-extended byte to the stack pointer.
// - Stack-word-offset adds a 16-bit offset to the stack pointer.
// - Any reset abandons current activity at once.
// - After reset, six cycles fetch vector from top two addresses and fill queue.
// - Interrupts wait for instruction end, vector by priority latched at start.
// - Stack counter low, counter high, low index, working register, flags in order.
// - Then set mask, fetch vector high, low, one free cycle, three bytes.
// - Upper index byte is never stacked by the sequence.
// - Software trap runs the same sequence but ignores the mask flag.
// - Wait clears mask, stops clocks; interrupt or reset restarts them.
// - Debug entry command during wait restarts clocks into background mode.
// - Stop may keep a minimal clock set for an internal periodic wake.
// - With debug enabled oscillator runs in stop; debug entry wakes it.
// - Debug halt enters background; only reset or host resume commands leave.
// - The mask flag sits at bit 3 of the flags register.
//
// Top of the address and exception sequencer: drives the memory bus for
// reset, interrupt and trap, and sequences wait, stop and background entry.
// Assumes the datapath holds registers and the bus answers reads the next cycle.
// Assumes the datapath applies the bump, pointer and counter loads.
`timescale 1ns/10ps
`include "caes_consts.vh"

module caes_sequencer (
  input  wire        sys_clk,      // 100 MHz clock
  input  wire        reset_n,      // Async reset, any source, active low
  input  wire        srcDone,      // Reset source determination finished
  input  wire        resetPin_n,   // External reset pin level
  input  wire        instrEnd,     // Datapath at an instruction boundary
  input  wire        opFetch,      // Operand fetch cycle of current instruction
  input  wire [3:0]  addrMode,     // Operand address mode
  input  wire [15:0] operandWord,  // Operand bytes from instruction
  input  wire [15:0] indexPair,    // Upper and low index bytes
  input  wire [15:0] stackPtr,     // Stack pointer
  input  wire [15:0] progCounter,  // Return address
  input  wire [7:0]  workReg,      // Working register
  input  wire [7:0]  flagsReg,     // Condition flags register
  input  wire [7:0]  irqReq,       // Interrupt requests, bit 0 highest
  input  wire        trapOp,       // Software trap instruction decoded
  input  wire        waitOp,       // Wait instruction decoded
  input  wire        stopOp,       // Stop instruction decoded
  input  wire        haltOp,       // Debug halt instruction decoded
  input  wire        debugEntryCmd,// Debug entry command from host
  input  wire        resumeCmd,    // Resume, single step or tagged resume
  input  wire        debugModeEn,  // Debug mode enable bit
  input  wire        keepClkStop,  // Keep minimal clocks in stop
  input  wire        periodicWake, // Internal periodic wake signal
  input  wire        extWake,      // External wake-up
  input  wire [7:0]  busRdata,     // Read data from memory bus
  output reg  [15:0] busAddr_r,    // Memory bus address
  output reg  [7:0]  busWdata_r,   // Memory bus write data
  output reg         busRd_r,      // Read strobe
  output reg         busWr_r,      // Write strobe
  output reg  [15:0] effAddr_r,    // Registered operand address
  output reg         indexInc_r,   // Pulse: bump the index pair by one
  output reg  [15:0] newIndex_r,   // Index pair value after the bump
  output reg  [15:0] newPc_r,      // Vector target loaded into counter
  output reg         pcLoad_r,     // Pulse: load newPc_r
  output reg         maskSet_r,    // Pulse: set flags bit 3
  output reg         maskClr_r,    // Pulse: clear flags bit 3
  output reg  [7:0]  spDec_r,      // Bytes pushed in the sequence
  output reg         cpuClkEn_r,   // CPU clock enable
  output reg         oscEn_r,      // Oscillator enable
  output reg         minClkEn_r,   // Minimal clock set enable
  output reg         bgActive_r,   // Active background mode
  output reg         seqBusy_r     // Sequence in progress
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_RST   = 4'h0;
  localparam [3:0] ST_RVEC  = 4'h1;
  localparam [3:0] ST_RUN   = 4'h2;
  localparam [3:0] ST_PUSH  = 4'h3;
  localparam [3:0] ST_VECHI = 4'h4;
  localparam [3:0] ST_VECLO = 4'h5;
  localparam [3:0] ST_FREE  = 4'h6;
  localparam [3:0] ST_QUEUE = 4'h7;
  localparam [3:0] ST_WAIT  = 4'h8;
  localparam [3:0] ST_STOP  = 4'h9;
  localparam [3:0] ST_DEBUG_HALT_INSTRUCTION  = 4'hA;

  // Trap vector sits above the interrupt vectors, two bytes each.
  localparam [15:0] TRAP_VEC = 16'hFFFC;
  localparam [15:0] IRQ_BASE = 16'hFFEC;

  reg  [3:0]  state_r;
  reg  [2:0]  cnt_r;
  reg  [15:0] vecAddr_r;
  // Frozen at the boundary so all pushes see one set
  reg  [15:0] retPc_r;
  reg  [7:0]  savX_r;
  reg  [7:0]  savA_r;
  reg  [7:0]  savF_r;

  wire [15:0] effAddr;
  wire        postInc;
  wire [2:0]  winIdx;
  wire        anyReq;
  // Live mask: a clear counts from the next boundary
  wire        maskOn = flagsReg[`CAES_MASK_BIT];
  wire        irqTake = anyReq & ~maskOn;

  // ----------------------------------------
  // Operand address and request priority
  // ----------------------------------------
  caes_addr_gen uAddr (
    .addrMode    (addrMode),
    .operandWord (operandWord),
    .indexPair   (indexPair),
    .stackPtr    (stackPtr),
    .effAddr     (effAddr),
    .postInc     (postInc)
  );

  caes_prio_enc uPrio (
    .reqLines (irqReq),
    .winIdx   (winIdx),
    .anyReq   (anyReq)
  );

  // ----------------------------------------
  // Push byte select
  // ----------------------------------------
  reg [7:0] pushByte;
  always @* begin
    case (cnt_r)
      3'h0:    pushByte = retPc_r[7:0];
      3'h1:    pushByte = retPc_r[15:8];
      3'h2:    pushByte = savX_r;
      3'h3:    pushByte = savA_r;
      3'h4:    pushByte = savF_r;
      default: pushByte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_RST;
      cnt_r      <= 3'h0;
      vecAddr_r  <= 16'h0000;
      retPc_r    <= 16'h0000;
      savX_r     <= 8'h00;
      savA_r     <= 8'h00;
      savF_r     <= 8'h00;
      busAddr_r  <= 16'h0000;
      busWdata_r <= 8'h00;
      busRd_r    <= 1'b0;
      busWr_r    <= 1'b0;
      effAddr_r  <= 16'h0000;
      indexInc_r <= 1'b0;
      newIndex_r <= 16'h0000;
      newPc_r    <= 16'h0000;
      pcLoad_r   <= 1'b0;
      maskSet_r  <= 1'b0;
      maskClr_r  <= 1'b0;
      spDec_r    <= 8'h00;
      cpuClkEn_r <= 1'b1;
      oscEn_r    <= 1'b1;
      minClkEn_r <= 1'b0;
      bgActive_r <= 1'b0;
      seqBusy_r  <= 1'b1;
    end else begin
      busRd_r    <= 1'b0;
      busWr_r    <= 1'b0;
      indexInc_r <= 1'b0;
      pcLoad_r   <= 1'b0;
      maskSet_r  <= 1'b0;
      maskClr_r  <= 1'b0;
      effAddr_r  <= effAddr;

      // Registered every cycle; only the bump is gated
      if (opFetch && postInc) begin
        indexInc_r <= 1'b1;
        newIndex_r <= indexPair + `CAES_INC_ONE;
      end

      case (state_r)
        ST_RST: begin
          // Held until source check is done and the pin has let go
          if (srcDone && resetPin_n) begin
            state_r <= ST_RVEC;
            cnt_r   <= 3'h0;
          end
        end

        ST_RVEC: begin
          // Bytes land two cycles after the strobe; last slot idles
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h0) begin
            busAddr_r <= `CAES_RESET_VEC_HI;
            busRd_r   <= 1'b1;
          end else if (cnt_r == 3'h1) begin
            busAddr_r <= `CAES_RESET_VEC_LO;
            busRd_r   <= 1'b1;
          end else if (cnt_r == 3'h2) begin
            newPc_r[15:8] <= busRdata;
          end else if (cnt_r == 3'h3) begin
            newPc_r[7:0] <= busRdata;
            pcLoad_r     <= 1'b1;
            busAddr_r    <= {newPc_r[15:8], busRdata};
            busRd_r      <= 1'b1;
          end else begin
            busAddr_r <= busAddr_r + `CAES_INC_ONE;
            busRd_r   <= (cnt_r != `CAES_RESET_CYCLES - 3'h1);
          end
          if (cnt_r == `CAES_RESET_CYCLES - 3'h1) begin
            state_r   <= ST_RUN;
            seqBusy_r <= 1'b0;
          end
        end

        ST_RUN: begin
          // Halt, then trap, then request, then wait, then stop
          if (instrEnd) begin
            retPc_r <= progCounter;
            savX_r  <= indexPair[7:0];
            savA_r  <= workReg;
            savF_r  <= flagsReg;
            cnt_r   <= 3'h0;
            if (haltOp) begin
              state_r    <= ST_DEBUG_HALT_INSTRUCTION;
              bgActive_r <= 1'b1;
            end else if (trapOp) begin
              vecAddr_r <= TRAP_VEC;
              state_r   <= ST_PUSH;
              seqBusy_r <= 1'b1;
            end else if (irqTake) begin
              // Priority frozen here for the whole sequence
              vecAddr_r <= IRQ_BASE - {12'h000, winIdx, 1'b0};
              state_r   <= ST_PUSH;
              seqBusy_r <= 1'b1;
            end else if (waitOp) begin
              maskClr_r  <= 1'b1;
              cpuClkEn_r <= 1'b0;
              state_r    <= ST_WAIT;
            end else if (stopOp) begin
              cpuClkEn_r <= 1'b0;
              oscEn_r    <= debugModeEn;
              minClkEn_r <= keepClkStop & ~debugModeEn;
              state_r    <= ST_STOP;
            end
          end
        end

        ST_PUSH: begin
          // Stack grows downward; the datapath moves the pointer
          busAddr_r  <= stackPtr - {13'h0000, cnt_r};
          busWdata_r <= pushByte;
          busWr_r    <= 1'b1;
          cnt_r      <= cnt_r + 3'h1;
          if (cnt_r == `CAES_STACK_BYTES - 3'h1) begin
            spDec_r   <= {5'h00, `CAES_STACK_BYTES};
            maskSet_r <= 1'b1;
            state_r   <= ST_VECHI;
          end
        end

        ST_VECHI: begin
          busAddr_r <= vecAddr_r;
          busRd_r   <= 1'b1;
          state_r   <= ST_VECLO;
        end

        ST_VECLO: begin
          busAddr_r <= vecAddr_r + `CAES_INC_ONE;
          busRd_r   <= 1'b1;
          state_r   <= ST_FREE;
        end

        ST_FREE: begin
          // High byte arrives here; bus left idle for one cycle
          newPc_r[15:8] <= busRdata;
          state_r       <= ST_QUEUE;
          cnt_r         <= 3'h0;
        end

        ST_QUEUE: begin
          // First read leaves as the low vector byte lands
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h0) begin
            newPc_r[7:0] <= busRdata;
            pcLoad_r     <= 1'b1;
            busAddr_r    <= {newPc_r[15:8], busRdata};
            busRd_r      <= 1'b1;
          end else begin
            busAddr_r <= busAddr_r + `CAES_INC_ONE;
            busRd_r   <= 1'b1;
          end
          if (cnt_r == {1'b0, `CAES_QUEUE_BYTES} - 3'h1) begin
            state_r   <= ST_RUN;
            seqBusy_r <= 1'b0;
          end
        end

        ST_WAIT: begin
          // No mask test: the wait cleared the mask
          if (debugEntryCmd) begin
            cpuClkEn_r <= 1'b1;
            bgActive_r <= 1'b1;
            state_r    <= ST_DEBUG_HALT_INSTRUCTION;
          end else if (anyReq) begin
            cpuClkEn_r <= 1'b1;
            state_r    <= ST_RUN;
          end
        end

        ST_STOP: begin
          // Debug entry is refused unless the oscillator ran
          if (debugEntryCmd && debugModeEn) begin
            cpuClkEn_r <= 1'b1;
            oscEn_r    <= 1'b1;
            minClkEn_r <= 1'b0;
            bgActive_r <= 1'b1;
            state_r    <= ST_DEBUG_HALT_INSTRUCTION;
          end else if (extWake || anyReq || (minClkEn_r && periodicWake)) begin
            cpuClkEn_r <= 1'b1;
            oscEn_r    <= 1'b1;
            minClkEn_r <= 1'b0;
            state_r    <= ST_RUN;
          end
        end

        ST_DEBUG_HALT_INSTRUCTION: begin
          if (resumeCmd) begin
            bgActive_r <= 1'b0;
            state_r    <= ST_RUN;
          end
        end

        default: state_r <= ST_RST;
      endcase
    end
  end

endmodule

//--- tb/caes_mem_model.sv
// Memory partner: byte store that answers a read one cycle after its strobe.
// Assumes one-cycle registered strobes from the sequencer.
`timescale 1ns/10ps

module caes_mem_model (
  input  wire        sys_clk,    // Bus clock
  input  wire [15:0] busAddr_r,  // Address
  input  wire [7:0]  busWdata_r, // Write data
  input  wire        busRd_r,    // Read strobe
  input  wire        busWr_r,    // Write strobe
  output reg  [7:0]  busRdata    // Read data
);
  reg     [7:0] mem [0:65535];
  integer       k;

  initial begin
    busRdata = 8'h00;
    for (k = 0; k < 65536; k = k + 1) begin
      mem[k] = k[7:0] ^ k[15:8] ^ 8'h5A;
    end
  end

  // Outside a read the data lines toggle, so stale data never matches
  always @(posedge sys_clk) begin
    if (busWr_r) begin
      mem[busAddr_r] <= busWdata_r;
    end
    busRdata <= busRd_r ? mem[busAddr_r] : ~busRdata;
  end
endmodule

//--- tb/caes_seq_chk.sv
// Checker for the sequencer's bus, address and stacking behaviour.
// Assumes the datapath levels stay steady through a sequence.
`timescale 1ns/10ps

module caes_seq_chk (
  input wire        sys_clk,     // Clock
  input wire        reset_n,     // Reset
  input wire        opFetch,     // Operand fetch
  input wire [3:0]  addrMode,    // Mode
  input wire [15:0] operandWord, // Operand
  input wire [15:0] indexPair,   // Index pair
  input wire [15:0] stackPtr,    // Stack pointer
  input wire [15:0] progCounter, // Return address
  input wire [7:0]  workReg,     // Working register
  input wire [7:0]  flagsReg,    // Flags
  input wire        instrEnd,    // Boundary
  input wire [7:0]  irqReq,      // Requests
  input wire        trapOp,      // Trap
  input wire [15:0] busAddr_r,   // Address
  input wire [7:0]  busWdata_r,  // Write data
  input wire        busRd_r,     // Read strobe
  input wire        busWr_r,     // Write strobe
  input wire [15:0] effAddr_r,   // Operand address
  input wire        indexInc_r,  // Bump pulse
  input wire [15:0] newIndex_r,  // Bumped index
  input wire        pcLoad_r,    // Counter load
  input wire        maskSet_r,   // Mask set
  input wire        seqBusy_r    // Busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_push;
    busWr_r && busAddr_r == stackPtr && busWdata_r == progCounter[7:0] ##1
    busWr_r && busAddr_r == stackPtr - 16'h0001 && busWdata_r == progCounter[15:8] ##1
    busWr_r && busAddr_r == stackPtr - 16'h0002 && busWdata_r == indexPair[7:0] ##1
    busWr_r && busAddr_r == stackPtr - 16'h0003 && busWdata_r == workReg ##1
    busWr_r && busAddr_r == stackPtr - 16'h0004 && busWdata_r == flagsReg;
  endsequence
  sequence s_vec;
    busRd_r && !busWr_r ##1 busRd_r && busAddr_r == $past(busAddr_r) + 16'h0001 ##1
    !busRd_r && !busWr_r ##1 pcLoad_r && busRd_r ##1 busRd_r ##1 busRd_r;
  endsequence

  a_page0_addr: assert property (opFetch && addrMode == 4'h0 |=>
    effAddr_r == (16'h00FF & $past(operandWord))) else $error("page zero address wrong");
  a_stk_word: assert property (opFetch && addrMode == 4'h8 |=>
    effAddr_r == $past(stackPtr) + $past(operandWord)) else $error("stack word sum wrong");
  a_post_inc: assert property (opFetch && (addrMode == 4'h3 || addrMode == 4'h5) |=>
    indexInc_r && newIndex_r == $past(indexPair) + 16'h0001) else $error("no bump");
  a_reset_vec: assert property (busRd_r && busAddr_r == 16'hFFFE |=> busRd_r &&
    busAddr_r == 16'hFFFF ##2 pcLoad_r && busRd_r ##1 busRd_r) else $error("reset fetch");
  a_push_order: assert property (instrEnd && !seqBusy_r && (trapOp || (irqReq != 8'h00 &&
    !flagsReg[3])) |=> ##1 s_push) else $error("stacking order wrong");
  a_vec_fetch: assert property (busWr_r && busAddr_r == stackPtr - 16'h0004 |->
    maskSet_r ##1 s_vec) else $error("vector fetch order wrong");
  a_irq_masked: assert property (instrEnd && !seqBusy_r && !trapOp && flagsReg[3] |=>
    ##1 !busWr_r) else $error("masked request taken");
  a_trap_nomask: assert property (instrEnd && !seqBusy_r && trapOp && flagsReg[3] |=>
    ##1 busWr_r && busAddr_r == stackPtr) else $error("trap was masked");
endmodule

bind caes_sequencer caes_seq_chk u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .opFetch(opFetch), .addrMode(addrMode),
  .operandWord(operandWord), .indexPair(indexPair), .stackPtr(stackPtr),
  .progCounter(progCounter), .workReg(workReg), .flagsReg(flagsReg), .instrEnd(instrEnd),
  .irqReq(irqReq), .trapOp(trapOp), .busAddr_r(busAddr_r), .busWdata_r(busWdata_r),
  .busRd_r(busRd_r), .busWr_r(busWr_r), .effAddr_r(effAddr_r), .indexInc_r(indexInc_r),
  .newIndex_r(newIndex_r), .pcLoad_r(pcLoad_r), .maskSet_r(maskSet_r),
  .seqBusy_r(seqBusy_r));

//--- tb/test_cpu_address_and_exception_sequencer.sv
// Testbench for the sequencer: address modes, reset, interrupts, low power, debug.
// Assumes the memory partner model and a 100 MHz clock.
`timescale 1ns/10ps

module test_cpu_address_and_exception_sequencer;
  reg         sys_clk, reset_n, srcDone, resetPin_n, instrEnd, opFetch, trapOp, waitOp;
  reg         stopOp, haltOp, debugEntryCmd, resumeCmd, debugModeEn, keepClkStop;
  reg         periodicWake, extWake;
  reg  [3:0]  addrMode;
  reg  [15:0] operandWord, indexPair, stackPtr, progCounter;
  reg  [7:0]  workReg, flagsReg, irqReq;
  wire [7:0]  busRdata, busWdata_r, spDec_r;
  wire [15:0] busAddr_r, effAddr_r, newIndex_r, newPc_r;
  wire        busRd_r, busWr_r, indexInc_r, pcLoad_r, maskSet_r, maskClr_r, cpuClkEn_r;
  wire        oscEn_r, minClkEn_r, bgActive_r, seqBusy_r;
  integer     error_cnt, tests_run, seed, i, n;

  caes_sequencer DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .srcDone(srcDone), .resetPin_n(resetPin_n),
    .instrEnd(instrEnd), .opFetch(opFetch), .addrMode(addrMode), .operandWord(operandWord),
    .indexPair(indexPair), .stackPtr(stackPtr), .progCounter(progCounter),
    .workReg(workReg), .flagsReg(flagsReg), .irqReq(irqReq), .trapOp(trapOp),
    .waitOp(waitOp), .stopOp(stopOp), .haltOp(haltOp), .debugEntryCmd(debugEntryCmd),
    .resumeCmd(resumeCmd), .debugModeEn(debugModeEn), .keepClkStop(keepClkStop),
    .periodicWake(periodicWake), .extWake(extWake), .busRdata(busRdata),
    .busAddr_r(busAddr_r), .busWdata_r(busWdata_r), .busRd_r(busRd_r), .busWr_r(busWr_r),
    .effAddr_r(effAddr_r), .indexInc_r(indexInc_r), .newIndex_r(newIndex_r),
    .newPc_r(newPc_r), .pcLoad_r(pcLoad_r), .maskSet_r(maskSet_r), .maskClr_r(maskClr_r),
    .spDec_r(spDec_r), .cpuClkEn_r(cpuClkEn_r), .oscEn_r(oscEn_r),
    .minClkEn_r(minClkEn_r), .bgActive_r(bgActive_r), .seqBusy_r(seqBusy_r));
  caes_mem_model u_mem (.sys_clk(sys_clk), .busAddr_r(busAddr_r), .busWdata_r(busWdata_r),
    .busRd_r(busRd_r), .busWr_r(busWr_r), .busRdata(busRdata));

  // ----------------------------------------
  // Expectations and shared steps
  // ----------------------------------------
  function [7:0] memb(input [15:0] a);
    memb = a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function [15:0] expEff(input [3:0] m);
    case (m)
      4'h0: expEff = {8'h00, operandWord[7:0]};
      4'h1: expEff = operandWord;
      4'h2, 4'h3: expEff = indexPair;
      4'h4, 4'h5: expEff = indexPair + {8'h00, operandWord[7:0]};
      4'h6: expEff = indexPair + operandWord;
      4'h7: expEff = stackPtr + {8'h00, operandWord[7:0]};
      default: expEff = stackPtr + operandWord;
    endcase
  endfunction
  function lv(input integer s);
    case (s)
      0: lv = cpuClkEn_r;
      1: lv = bgActive_r;
      default: lv = maskClr_r;
    endcase
  endfunction
  task chk(input ok);
    begin
      tests_run = tests_run + 1;
      if (ok !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t mismatch at check %0d", $time, tests_run);
      end
    end
  endtask
  task waitLvl(input integer s, input v);
    begin
      n = 0;
      #1;
      while (lv(s) !== v && n < 40) begin
        @(posedge sys_clk) #1;
        n = n + 1;
      end
      chk(n < 40);
    end
  endtask
  task waitPc(input [15:0] v);
    begin
      n = 0;
      #1;
      while (pcLoad_r !== 1'b1 && n < 40) begin
        @(posedge sys_clk) #1;
        n = n + 1;
      end
      chk(n < 40 && newPc_r === {memb(v), memb(v + 16'h0001)});
    end
  endtask
  // Waits for an idle sequencer so a boundary is never offered mid-sequence
  task boundary(input t, input w, input s, input h);
    begin
      n = 0;
      @(posedge sys_clk) #1;
      while (seqBusy_r !== 1'b0 && n < 40) begin
        @(posedge sys_clk) #1;
        n = n + 1;
      end
      @(posedge sys_clk) {instrEnd, trapOp, waitOp, stopOp, haltOp} <= {1'b1, t, w, s, h};
      @(posedge sys_clk) {instrEnd, trapOp, waitOp, stopOp, haltOp} <= 5'h00;
    end
  endtask
  task cmd(input entry);
    begin
      @(posedge sys_clk) {debugEntryCmd, resumeCmd} <= {entry, !entry};
      @(posedge sys_clk) {debugEntryCmd, resumeCmd} <= 2'h0;
    end
  endtask
  task summarize;
    begin
      $display("Mismatches %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    summarize;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h9E17F255;
    error_cnt = 0;
    tests_run = 0;
    {srcDone, instrEnd, opFetch, trapOp, waitOp, stopOp, haltOp, debugEntryCmd, resumeCmd,
     debugModeEn, keepClkStop, periodicWake, extWake, addrMode, operandWord, indexPair,
     progCounter, workReg, flagsReg, irqReq} = 0;
    {resetPin_n, stackPtr, reset_n} = {1'b1, 16'h0180, 1'b0};
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk(busRd_r === 1'b0);
    @(posedge sys_clk) srcDone <= 1'b1;
    waitPc(16'hFFFE);
    for (i = 0; i < 60; i = i + 1) begin
      @(posedge sys_clk);
      addrMode <= (i < 9) ? i : {$random(seed)} % 9;
      operandWord <= (i == 4) ? 16'hFFFF : $random(seed);
      indexPair <= (i == 3 || i == 4) ? 16'hFFFF : $random(seed);
      opFetch <= 1'b1;
      @(posedge sys_clk) opFetch <= 1'b0;
      #1 chk(effAddr_r === expEff(addrMode));
      if (addrMode == 4'h3 || addrMode == 4'h5) begin
        chk(indexInc_r === 1'b1 && newIndex_r === indexPair + 16'h0001);
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge sys_clk) irqReq <= (8'h01 << i) | ($random(seed) & (8'hFE << i));
      {progCounter, workReg, flagsReg} <= {$random(seed), 8'h00} & 32'hFFFF_FFF7;
      boundary(1'b0, 1'b0, 1'b0, 1'b0);
      waitPc(16'(16'hFFEC - 2 * i));
      chk(spDec_r === 8'h05);
      @(posedge sys_clk) irqReq <= 8'h00;
    end
    @(posedge sys_clk) {flagsReg, irqReq} <= 16'h0810;
    boundary(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (12) @(posedge sys_clk) #1 chk(pcLoad_r === 1'b0);
    boundary(1'b1, 1'b0, 1'b0, 1'b0);
    waitPc(16'hFFFC);
    @(posedge sys_clk) irqReq <= 8'h00;
    boundary(1'b0, 1'b1, 1'b0, 1'b0);
    waitLvl(2, 1'b1);
    waitLvl(0, 1'b0);
    @(posedge sys_clk) {flagsReg, irqReq} <= 16'h0004;
    waitLvl(0, 1'b1);
    boundary(1'b0, 1'b0, 1'b0, 1'b0);
    waitPc(16'hFFE8);
    @(posedge sys_clk) irqReq <= 8'h00;
    boundary(1'b0, 1'b1, 1'b0, 1'b0);
    waitLvl(0, 1'b0);
    cmd(1'b1);
    waitLvl(1, 1'b1);
    chk(cpuClkEn_r === 1'b1);
    cmd(1'b0);
    waitLvl(1, 1'b0);
    debugModeEn <= 1'b1;
    boundary(1'b0, 1'b0, 1'b1, 1'b0);
    waitLvl(0, 1'b0);
    chk(oscEn_r === 1'b1);
    cmd(1'b1);
    waitLvl(1, 1'b1);
    cmd(1'b0);
    waitLvl(1, 1'b0);
    {debugModeEn, keepClkStop} <= 2'h1;
    boundary(1'b0, 1'b0, 1'b1, 1'b0);
    waitLvl(0, 1'b0);
    chk(minClkEn_r === 1'b1);
    cmd(1'b1);
    repeat (4) @(posedge sys_clk);
    #1 chk(bgActive_r === 1'b0 && cpuClkEn_r === 1'b0);
    periodicWake <= 1'b1;
    waitLvl(0, 1'b1);
    @(posedge sys_clk) {periodicWake, keepClkStop} <= 2'h0;
    boundary(1'b0, 1'b0, 1'b1, 1'b0);
    waitLvl(0, 1'b0);
    chk(oscEn_r === 1'b0);
    @(posedge sys_clk) extWake <= 1'b1;
    waitLvl(0, 1'b1);
    @(posedge sys_clk) extWake <= 1'b0;
    boundary(1'b0, 1'b0, 1'b0, 1'b1);
    waitLvl(1, 1'b1);
    cmd(1'b0);
    waitLvl(1, 1'b0);
    @(posedge sys_clk) {flagsReg, irqReq} <= 16'h0001;
    boundary(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk) reset_n <= 1'b0;
    #1 chk(busWr_r === 1'b0 && busRd_r === 1'b0 && seqBusy_r === 1'b1);
    repeat (3) @(posedge sys_clk);
    {irqReq, reset_n} <= 9'h001;
    waitPc(16'hFFFE);
    summarize;
  end
endmodule
